// [verilog/bst_pkg.sv]
// Constants and types shared by the boundary-scan test access port.
package bst_pkg;

  // --------------------------------------------------------------------------
  // Register sizes
  // --------------------------------------------------------------------------
  localparam int NUM_PORTS      = 4;
  localparam int CELLS_PER_PORT = 2;
  localparam int CELL_IN_OFS    = 0;
  localparam int CELL_OUT_OFS   = 1;
  localparam int CHAIN_LEN      = CELLS_PER_PORT * NUM_PORTS;
  localparam int INSTR_LEN      = 4;
  localparam int ID_LEN         = 32;

  // --------------------------------------------------------------------------
  // Instruction codes and reset values
  // --------------------------------------------------------------------------
  localparam logic [INSTR_LEN-1:0] INSTR_EXTEST  = 4'h0;
  localparam logic [INSTR_LEN-1:0] INSTR_SAMPLE  = 4'h1;
  localparam logic [INSTR_LEN-1:0] INSTR_IDCODE  = 4'h2;
  localparam logic [INSTR_LEN-1:0] INSTR_CLAMP   = 4'h3;
  localparam logic [INSTR_LEN-1:0] INSTR_HIGHZ   = 4'h4;
  localparam logic [INSTR_LEN-1:0] INSTR_BYPASS  = 4'hf;
  localparam logic [INSTR_LEN-1:0] INSTR_CAPTURE = 4'h1;
  localparam logic [INSTR_LEN-1:0] INSTR_RESET   = INSTR_IDCODE;

  // --------------------------------------------------------------------------
  // Identity fields; the values are arbitrary
  // --------------------------------------------------------------------------
  localparam logic [3:0]        ID_VERSION = 4'h1;
  localparam logic [15:0]       ID_PART    = 16'h0a5c;
  localparam logic [10:0]       ID_MAKER   = 11'h2a6;
  localparam logic              ID_FIXED   = 1'b1;
  localparam logic [ID_LEN-1:0] ID_VALUE   = {ID_VERSION, ID_PART, ID_MAKER, ID_FIXED};

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE,
    ST_SEL_DATA, ST_CAP_DATA, ST_SH_DATA, ST_EX1_DATA,
    ST_PAU_DATA, ST_EX2_DATA, ST_UPD_DATA,
    ST_SEL_INSTR, ST_CAP_INSTR, ST_SH_INSTR, ST_EX1_INSTR,
    ST_PAU_INSTR, ST_EX2_INSTR, ST_UPD_INSTR
  } bst_state_t;

  typedef enum logic [1:0] {DR_PASS, DR_ID, DR_CHAIN} bst_dr_sel_t;

endpackage : bst_pkg

// [verilog/bst_sync.sv]
// Two-flop level synchroniser for static bits entering a clock domain.
`timescale 1ns/1ps
module bst_sync
  import bst_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // Destination clock and reset.
  input  wire logic             clk,
  input  wire logic             rstN,
  // Level from the far domain and its local copy.
  input  wire logic [WIDTH-1:0] levelIn,
  output logic      [WIDTH-1:0] levelOut
);

  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;

  // The first stage is read by the second stage only.
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      stage1_q <= '0;
      stage2_q <= '0;
    end
    else
    begin
      stage1_q <= levelIn;
      stage2_q <= stage1_q;
    end
  end

  assign levelOut = stage2_q;

endmodule : bst_sync

// [verilog/bst_tap_fsm.sv]
// Sixteen-state test access port controller with decoded strobes.
`timescale 1ns/1ps
module bst_tap_fsm
  import bst_pkg::*;
(
  // Test clock and its reset.
  input  wire logic tck,
  input  wire logic rstN,
  // Mode select, sampled on the rising test clock.
  input  wire logic tms,
  // Controller state and strobes.
  output bst_state_t state,
  output logic       captureData,
  output logic       shiftData,
  output logic       updateData,
  output logic       captureInstr,
  output logic       shiftInstr,
  output logic       updateInstr
);

  bst_state_t state_q;
  bst_state_t state_d;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_RESET:     state_d = tms ? ST_RESET     : ST_IDLE;
      ST_IDLE:      state_d = tms ? ST_SEL_DATA  : ST_IDLE;
      ST_SEL_DATA:  state_d = tms ? ST_SEL_INSTR : ST_CAP_DATA;
      ST_CAP_DATA:  state_d = tms ? ST_EX1_DATA  : ST_SH_DATA;
      ST_SH_DATA:   state_d = tms ? ST_EX1_DATA  : ST_SH_DATA;
      ST_EX1_DATA:  state_d = tms ? ST_UPD_DATA  : ST_PAU_DATA;
      ST_PAU_DATA:  state_d = tms ? ST_EX2_DATA  : ST_PAU_DATA;
      ST_EX2_DATA:  state_d = tms ? ST_UPD_DATA  : ST_SH_DATA;
      ST_UPD_DATA:  state_d = tms ? ST_SEL_DATA  : ST_IDLE;
      ST_SEL_INSTR: state_d = tms ? ST_RESET     : ST_CAP_INSTR;
      ST_CAP_INSTR: state_d = tms ? ST_EX1_INSTR : ST_SH_INSTR;
      ST_SH_INSTR:  state_d = tms ? ST_EX1_INSTR : ST_SH_INSTR;
      ST_EX1_INSTR: state_d = tms ? ST_UPD_INSTR : ST_PAU_INSTR;
      ST_PAU_INSTR: state_d = tms ? ST_EX2_INSTR : ST_PAU_INSTR;
      ST_EX2_INSTR: state_d = tms ? ST_UPD_INSTR : ST_SH_INSTR;
      ST_UPD_INSTR: state_d = tms ? ST_SEL_DATA  : ST_IDLE;
      default:      state_d = ST_RESET;
    endcase
  end

  // State steps on every rising test clock.
  always_ff @(posedge tck or negedge rstN)
  begin
    if (!rstN)
      state_q <= ST_RESET;
    else
      state_q <= state_d;
  end

  // Strobes decoded from the present state.
  assign state        = state_q;
  assign captureData  = (state_q == ST_CAP_DATA);
  assign shiftData    = (state_q == ST_SH_DATA);
  assign updateData   = (state_q == ST_UPD_DATA);
  assign captureInstr = (state_q == ST_CAP_INSTR);
  assign shiftInstr   = (state_q == ST_SH_INSTR);
  assign updateInstr  = (state_q == ST_UPD_INSTR);

  default clocking fsmClk @(posedge tck);
  endclocking
  default disable iff (!rstN);

  a_tms_reset: assert property (tms [*5] |=> state_q == ST_RESET)
    else $error("Five high mode-select edges did not reach reset.");
  a_shift_hold: assert property ((state_q == ST_SH_DATA) && !tms |=> state_q == ST_SH_DATA)
    else $error("Shift state left with mode-select low.");
  a_update_idle: assert property ((state_q == ST_UPD_DATA) && !tms |=> state_q == ST_IDLE)
    else $error("Update did not return to idle.");

endmodule : bst_tap_fsm

// [verilog/bst_tap.sv]
// Boundary-scan test access port with chain, identity and pass-through paths.
// Summary of operation
// - Standard boundary-scan test logic built around a test access port controller.
// - Controller state is steered by the mode-select and test clock pins, and forced to reset by nrst.
// - Serial data enters on data in and leaves on data out at test clock.
// - Four scan registers: boundary chain, identity, one-bit pass-through, instruction.
// - Instruction register and decoder choose the test and the data path.
// - Supports EXTEST, SAMPLE/PRELOAD, IDCODE, BYPASS, CLAMP and HIGHZ.
// - Identity holds version, part number, maker code and a fixed one.
// - Pass-through register is one bit, a single stage from in to out.
// - Each port has an observe-only input cell and a controllable output cell.
// - Controller is a sixteen-state synchronous machine with two branches.
// - Every transition follows mode-select sampled on the rising test clock.
`timescale 1ns/1ps
module bst_tap
  import bst_pkg::*;
(
  // System clock and reset.
  input  wire logic                 ref_clk,
  input  wire logic                 nrst,
  // Test access port pins.
  input  wire logic                 tck,
  input  wire logic                 tms,
  input  wire logic                 tdi,
  output logic                      tdo,
  output logic                      tdoEn,
  // Core side of the bidirectional ports.
  input  wire logic [NUM_PORTS-1:0] coreOut,
  input  wire logic [NUM_PORTS-1:0] coreOe,
  output logic      [NUM_PORTS-1:0] coreIn,
  // Pad side of the bidirectional ports.
  input  wire logic [NUM_PORTS-1:0] padIn,
  output logic      [NUM_PORTS-1:0] padOut,
  output logic      [NUM_PORTS-1:0] padOe
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic                 rstSyncN;
  logic                 tckRstN;
  logic [NUM_PORTS-1:0] padInTck;
  logic [NUM_PORTS-1:0] coreOutTck;
  logic [NUM_PORTS-1:0] padInRef;
  bst_state_t           tapState;
  logic                 captureData;
  logic                 shiftData;
  logic                 updateData;
  logic                 captureInstr;
  logic                 shiftInstr;
  logic                 updateInstr;
  bst_dr_sel_t          drSel;
  logic [INSTR_LEN-1:0] instrShift_q;
  logic [INSTR_LEN-1:0] instr_q;
  logic                 passBit_q;
  logic [ID_LEN-1:0]    idShift_q;
  logic [CHAIN_LEN-1:0] chainShift_q;
  logic [CHAIN_LEN-1:0] chainUpd_q;
  logic                 driveMode_q;
  logic                 hizMode_q;
  logic [NUM_PORTS-1:0] outUpd;
  logic [NUM_PORTS+1:0] modeRef;
  logic [NUM_PORTS-1:0] refOutUpd;
  logic                 refDrive;
  logic                 refHiz;
  logic                 serialBit;
  logic                 tdo_q;
  logic                 tdoEn_q;
  logic [NUM_PORTS-1:0] padOut_q;
  logic [NUM_PORTS-1:0] padOe_q;
  logic [NUM_PORTS-1:0] coreIn_q;

  // --------------------------------------------------------------------------
  // Decode helpers
  // --------------------------------------------------------------------------

  // Maps an instruction to the data register placed between the pins.
  function automatic bst_dr_sel_t drSelect(input logic [INSTR_LEN-1:0] code);
    bst_dr_sel_t sel;
    sel = DR_PASS;
    case (code)
      INSTR_EXTEST: sel = DR_CHAIN;
      INSTR_SAMPLE: sel = DR_CHAIN;
      INSTR_IDCODE: sel = DR_ID;
      default:      sel = DR_PASS;
    endcase
    return sel;
  endfunction : drSelect

  // --------------------------------------------------------------------------
  // Resets and crossings
  // --------------------------------------------------------------------------

  // Reset for the system clock domain, released after two edges.
  bst_sync #(
    .WIDTH (1)
  ) u_ref_rst (
    .clk      (ref_clk),
    .rstN     (nrst),
    .levelIn  (1'b1),
    .levelOut (rstSyncN)
  );

  // Reset for the test clock domain, asserted at once, released on tck.
  bst_sync #(
    .WIDTH (1)
  ) u_tck_rst (
    .clk      (tck),
    .rstN     (nrst),
    .levelIn  (1'b1),
    .levelOut (tckRstN)
  );

  // Pad levels brought onto the test clock for the input cells.
  bst_sync #(
    .WIDTH (NUM_PORTS)
  ) u_pad_tck (
    .clk      (tck),
    .rstN     (tckRstN),
    .levelIn  (padIn),
    .levelOut (padInTck)
  );

  // Core output levels brought onto the test clock for the output cells.
  bst_sync #(
    .WIDTH (NUM_PORTS)
  ) u_core_tck (
    .clk      (tck),
    .rstN     (tckRstN),
    .levelIn  (coreOut),
    .levelOut (coreOutTck)
  );

  // Pad levels brought onto the system clock for the core.
  bst_sync #(
    .WIDTH (NUM_PORTS)
  ) u_pad_ref (
    .clk      (ref_clk),
    .rstN     (rstSyncN),
    .levelIn  (padIn),
    .levelOut (padInRef)
  );

  // Test modes and output-cell values are static while applied, so a
  // per-bit level crossing settles them within two system clocks.
  bst_sync #(
    .WIDTH (NUM_PORTS + 2)
  ) u_mode_ref (
    .clk      (ref_clk),
    .rstN     (rstSyncN),
    .levelIn  ({hizMode_q, driveMode_q, outUpd}),
    .levelOut (modeRef)
  );

  assign refOutUpd = modeRef[NUM_PORTS-1:0];
  assign refDrive  = modeRef[NUM_PORTS];
  assign refHiz    = modeRef[NUM_PORTS+1];

  // --------------------------------------------------------------------------
  // Controller
  // --------------------------------------------------------------------------

  // Controller driven from mode-select and test clock, and reset from nrst through tckRstN.
  bst_tap_fsm u_fsm (
    .tck          (tck),
    .rstN         (tckRstN),
    .tms          (tms),
    .state        (tapState),
    .captureData  (captureData),
    .shiftData    (shiftData),
    .updateData   (updateData),
    .captureInstr (captureInstr),
    .shiftInstr   (shiftInstr),
    .updateInstr  (updateInstr)
  );

  // --------------------------------------------------------------------------
  // Instruction register
  // --------------------------------------------------------------------------

  // Instruction shift stage captures the fixed pattern, then shifts.
  always_ff @(posedge tck or negedge tckRstN)
  begin
    if (!tckRstN)
      instrShift_q <= INSTR_CAPTURE;
    else if (captureInstr)
      instrShift_q <= INSTR_CAPTURE;
    else if (shiftInstr)
      instrShift_q <= {tdi, instrShift_q[INSTR_LEN-1:1]};
  end

  // Reset state reloads the identity instruction.
  always_ff @(posedge tck or negedge tckRstN)
  begin
    if (!tckRstN)
      instr_q <= INSTR_RESET;
    else if (tapState == ST_RESET)
      instr_q <= INSTR_RESET;
    else if (updateInstr)
      instr_q <= instrShift_q;
  end

  // Decode of the active instruction into path and pin modes.
  assign drSel = drSelect(instr_q);

  // Pin modes load on the same edge as the active instruction. The test clock
  // may stop right after Update-IR, so a one-edge lag would never catch up.
  always_ff @(posedge tck or negedge tckRstN)
  begin
    if (!tckRstN)
    begin
      driveMode_q <= 1'b0;
      hizMode_q   <= 1'b0;
    end
    else if (tapState == ST_RESET)
    begin
      driveMode_q <= 1'b0;
      hizMode_q   <= 1'b0;
    end
    else if (updateInstr)
    begin
      driveMode_q <= (instrShift_q == INSTR_EXTEST) || (instrShift_q == INSTR_CLAMP);
      hizMode_q   <= (instrShift_q == INSTR_HIGHZ);
    end
  end

  // --------------------------------------------------------------------------
  // Data registers
  // --------------------------------------------------------------------------

  always_ff @(posedge tck or negedge tckRstN)
  begin
    if (!tckRstN)
      passBit_q <= 1'b0;
    else if (captureData && (drSel == DR_PASS))
      passBit_q <= 1'b0;
    else if (shiftData && (drSel == DR_PASS))
      passBit_q <= tdi;
  end

  // Identity register loads its fixed code and shifts it out.
  always_ff @(posedge tck or negedge tckRstN)
  begin
    if (!tckRstN)
      idShift_q <= ID_VALUE;
    else if (captureData && (drSel == DR_ID))
      idShift_q <= ID_VALUE;
    else if (shiftData && (drSel == DR_ID))
      idShift_q <= {tdi, idShift_q[ID_LEN-1:1]};
  end

  // Input cells observe pads; output cells observe core outputs.
  always_ff @(posedge tck or negedge tckRstN)
  begin
    if (!tckRstN)
      chainShift_q <= '0;
    else if (captureData && (drSel == DR_CHAIN))
    begin
      for (int i = 0; i < NUM_PORTS; i++)
      begin
        chainShift_q[CELLS_PER_PORT*i+CELL_IN_OFS]  <= padInTck[i];
        chainShift_q[CELLS_PER_PORT*i+CELL_OUT_OFS] <= coreOutTck[i];
      end
    end
    else if (shiftData && (drSel == DR_CHAIN))
      chainShift_q <= {tdi, chainShift_q[CHAIN_LEN-1:1]};
  end

  // Update stage takes EXTEST values or SAMPLE/PRELOAD data.
  always_ff @(posedge tck or negedge tckRstN)
  begin
    if (!tckRstN)
      chainUpd_q <= '0;
    else if (updateData && (drSel == DR_CHAIN))
      chainUpd_q <= chainShift_q;
  end

  // Output-cell update values, one per port.
  always_comb
  begin
    outUpd = '0;
    for (int i = 0; i < NUM_PORTS; i++)
      outUpd[i] = chainUpd_q[CELLS_PER_PORT*i+CELL_OUT_OFS];
  end

  // --------------------------------------------------------------------------
  // Serial output
  // --------------------------------------------------------------------------

  // Serial output picks one of the four scan registers.
  always_comb
  begin
    serialBit = passBit_q;
    if (shiftInstr)
      serialBit = instrShift_q[0];
    else
    begin
      case (drSel)
        DR_ID:    serialBit = idShift_q[0];
        DR_CHAIN: serialBit = chainShift_q[0];
        default:  serialBit = passBit_q;
      endcase
    end
  end

  // Data out and its enable change on the falling test clock.
  // Data moves at the test clock rate.
  always_ff @(negedge tck or negedge tckRstN)
  begin
    if (!tckRstN)
    begin
      tdo_q   <= 1'b0;
      tdoEn_q <= 1'b0;
    end
    else
    begin
      tdo_q   <= serialBit;
      tdoEn_q <= shiftData || shiftInstr;
    end
  end

  assign tdo   = tdo_q;
  assign tdoEn = tdoEn_q;

  // --------------------------------------------------------------------------
  // Pad and core muxing
  // --------------------------------------------------------------------------

  // Pads follow the core in normal use, the output cells under EXTEST and CLAMP; HIGHZ drops every enable.
  always_ff @(posedge ref_clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      padOut_q <= '0;
      padOe_q  <= '0;
      coreIn_q <= '0;
    end
    else
    begin
      padOut_q <= refDrive ? refOutUpd : coreOut;
      padOe_q  <= refHiz ? '0 : (refDrive ? '1 : coreOe);
      coreIn_q <= padInRef;
    end
  end

  assign padOut = padOut_q;
  assign padOe  = padOe_q;
  assign coreIn = coreIn_q;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------

  a_bypass_path: assert property (@(posedge tck) disable iff (!tckRstN)
    shiftData && (drSel == DR_PASS) |=> passBit_q == $past(tdi))
    else $error("Pass-through bit did not take data in.");
  a_id_capture: assert property (@(posedge tck) disable iff (!tckRstN)
    captureData && (drSel == DR_ID) |=> idShift_q == ID_VALUE)
    else $error("Identity code not captured.");
  a_instr_capture: assert property (@(posedge tck) disable iff (!tckRstN)
    captureInstr |=> instrShift_q == INSTR_CAPTURE)
    else $error("Instruction capture pattern wrong.");
  a_reset_instr: assert property (@(posedge tck) disable iff (!tckRstN)
    (tapState == ST_RESET) |=> (instr_q == INSTR_RESET) && (drSel == DR_ID))
    else $error("Reset state did not select the identity register.");
  a_tdo_enable: assert property (@(posedge tck) disable iff (!tckRstN)
    tdoEn_q == (shiftData || shiftInstr))
    else $error("Data out enabled outside a shift state.");
  a_hiz_pads: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
    refHiz |=> padOe_q == '0)
    else $error("Pads driven while high impedance mode is active.");
  a_extest_drive: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
    refDrive && !refHiz |=> padOut_q == $past(refOutUpd) && padOe_q == '1)
    else $error("Output cells not driving the pads.");

  c_bypass_shift: cover property (@(posedge tck) disable iff (!tckRstN)
    shiftData && (drSel == DR_PASS));
  c_id_shift: cover property (@(posedge tck) disable iff (!tckRstN)
    shiftData && (drSel == DR_ID));
  c_extest_on: cover property (@(posedge ref_clk) disable iff (!rstSyncN)
    refDrive && !refHiz);
  c_reset_idle: cover property (@(posedge tck) disable iff (!tckRstN)
    (tapState == ST_RESET) ##1 (tapState == ST_IDLE));

endmodule : bst_tap

// [dv/bst_ctl_model.sv]
// Behavioural test controller that walks the access port from outside.
`timescale 1ns/1ps
module bst_ctl_model (
  // Test access port pins.
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdoEn
);
  logic lastTdo;
  logic lastEn;

  // Pins start idle; the test clock stands low outside frames.
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  task automatic step(input logic m, input logic d);
    tms = m;
    tdi = d;
    #3;
    // A released data out shows the inverse of its last level.
    lastTdo = tdoEn ? tdo : ~tdo;
    lastEn  = tdoEn;
    tck     = 1'b1;
    #3;
    tck = 1'b0;
  endtask : step

  task automatic reset_tap();
    repeat (5) step(1'b1, tdi);
    step(1'b0, tdi);
  endtask : reset_tap

  // scan least significant bit first, optionally pausing midway
  task automatic scan(input logic isInstr, input int n, input logic [31:0] din, input logic slow,
                      output logic [31:0] dout, output logic enOk);
    dout = '0;
    enOk = 1'b1;
    step(1'b0, tdi);
    step(1'b0, tdi);
    step(1'b1, tdi);
    if (isInstr)
      step(1'b1, tdi);
    step(1'b0, tdi);
    step(1'b0, tdi);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1 || (slow && i == n / 2), din[i]);
      dout[i] = lastTdo;
      enOk    = enOk & lastEn;
      if (slow && i == n / 2 && i != n - 1)
      begin
        step(1'b0, tdi);
        step(1'b0, tdi);
        step(1'b1, tdi);
        step(1'b0, tdi);
      end
    end
    step(1'b1, tdi);
    // Data in toggles on the step from update to idle, where the port must ignore it.
    step(1'b0, ~tdi);
  endtask : scan
endmodule : bst_ctl_model

// [dv/bst_tap_tb.sv]
// Self-checking bench for the boundary-scan test access port.
`timescale 1ns/1ps
module bst_tap_tb
  import bst_pkg::*;
;
  logic                 ref_clk;
  logic                 nrst;
  logic                 tck, tms, tdi, tdo, tdoEn;
  logic [NUM_PORTS-1:0] coreOut, coreOe, coreIn, padIn, padOut, padOe;
  logic [31:0]          rd;
  logic                 en;
  int                   n_mismatch;
  int                   checks_done;

  bst_tap u_dut (.ref_clk(ref_clk), .nrst(nrst), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdoEn(tdoEn), .coreOut(coreOut), .coreOe(coreOe), .coreIn(coreIn),
    .padIn(padIn), .padOut(padOut), .padOe(padOe));
  bst_ctl_model u_ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoEn(tdoEn));

  // System clock at 50 MHz.
  initial ref_clk = 1'b0;
  always #10 ref_clk = ~ref_clk;

  // Compares one value and counts the outcome.
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, want, seen);
    end
  endtask : chk

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  // Output cell bits of a chain value.
  function automatic logic [NUM_PORTS-1:0] out_cells(input logic [CHAIN_LEN-1:0] v);
    for (int i = 0; i < NUM_PORTS; i++)
      out_cells[i] = v[CELLS_PER_PORT*i+CELL_OUT_OFS];
  endfunction : out_cells

  // Drives the core and pad inputs on the falling system clock.
  task automatic set_pads(input logic [NUM_PORTS-1:0] pi, co, oe);
    @(negedge ref_clk);
    padIn   = pi;
    coreOut = co;
    coreOe  = oe;
  endtask : set_pads

  // Loads an instruction, then lets the mode settle on the pad side.
  task automatic load_instr(input logic [INSTR_LEN-1:0] code);
    u_ctl.scan(1'b1, INSTR_LEN, 32'(code), 1'b0, rd, en);
    chk("instr capture", 32'(rd[INSTR_LEN-1:0]), 32'(INSTR_CAPTURE));
    chk("instr shift enable", 32'(en), 32'h1);
    chk("idle enable", 32'(tdoEn), 32'h0);
    repeat (8) @(negedge ref_clk);
  endtask : load_instr

  // Reads the identity register, pausing midway when slow is set.
  task automatic t_idcode(input logic slow);
    u_ctl.scan(1'b0, ID_LEN, 32'h0, slow, rd, en);
    chk("identity", rd, ID_VALUE);
    chk("fixed bit", 32'(rd[0]), 32'h1);
    chk("dr shift enable", 32'(en), 32'h1);
  endtask : t_idcode

  // A selected pass-through path delays the data by one stage.
  task automatic t_bypass(input logic [INSTR_LEN-1:0] code);
    load_instr(code);
    u_ctl.scan(1'b0, 8, 32'hb4, 1'b0, rd, en);
    chk("one bit path", rd, 32'h68);
  endtask : t_bypass

  // Samples the pads and core, preloading the chain meanwhile.
  task automatic t_sample();
    logic [CHAIN_LEN-1:0] expChain;
    set_pads(4'h6, 4'h9, 4'h3);
    load_instr(INSTR_SAMPLE);
    for (int i = 0; i < NUM_PORTS; i++)
    begin
      expChain[CELLS_PER_PORT*i+CELL_IN_OFS]  = padIn[i];
      expChain[CELLS_PER_PORT*i+CELL_OUT_OFS] = coreOut[i];
    end
    u_ctl.scan(1'b0, CHAIN_LEN, 32'h28, 1'b0, rd, en);
    chk("chain capture", rd, 32'(expChain));
    repeat (8) @(negedge ref_clk);
    chk("pad out", 32'(padOut), 32'(coreOut));
    chk("pad enable", 32'(padOe), 32'(coreOe));
    chk("core in", 32'(coreIn), 32'(padIn));
  endtask : t_sample

  // External test drives the pads from the output cells.
  task automatic t_extest();
    load_instr(INSTR_EXTEST);
    chk("extest drive", 32'(padOut), 32'(out_cells(8'h28)));
    chk("extest enable", 32'(padOe), 32'hf);
    u_ctl.scan(1'b0, CHAIN_LEN, 32'h08, 1'b0, rd, en);
    repeat (8) @(negedge ref_clk);
    chk("extest update", 32'(padOut), 32'(out_cells(8'h08)));
  endtask : t_extest

  // Clamp holds the pads with a short path; high impedance releases them.
  task automatic t_clamp();
    load_instr(INSTR_CLAMP);
    chk("clamp drive", 32'(padOut), 32'(out_cells(8'h08)));
    chk("clamp enable", 32'(padOe), 32'hf);
    u_ctl.scan(1'b0, 8, 32'hb4, 1'b0, rd, en);
    chk("clamp path", rd, 32'h68);
    load_instr(INSTR_HIGHZ);
    chk("highz enable", 32'(padOe), 32'h0);
    chk("highz value", 32'(padOut), 32'(coreOut));
  endtask : t_clamp

  // Leaves a shift midway by the reset walk; the identity path returns.
  task automatic t_abort();
    load_instr(INSTR_BYPASS);
    u_ctl.step(1'b1, 1'b0);
    u_ctl.step(1'b0, 1'b0);
    u_ctl.step(1'b0, 1'b0);
    u_ctl.step(1'b0, 1'b1);
    chk("mid shift enable", 32'(tdoEn), 32'h1);
    u_ctl.reset_tap();
    chk("reset enable", 32'(tdoEn), 32'h0);
    t_idcode(1'b0);
  endtask : t_abort

  // Main sequence.
  initial
  begin
    n_mismatch  = 0;
    checks_done = 0;
    nrst        = 1'b0;
    padIn       = '0;
    coreOut     = '0;
    coreOe      = '0;
    repeat (16) @(negedge ref_clk);
    chk("reset tdo", 32'({tdo, tdoEn}), 32'h0);
    nrst = 1'b1;
    repeat (4) @(negedge ref_clk);
    u_ctl.reset_tap();
    t_idcode(1'b1);
    t_bypass(INSTR_BYPASS);
    t_bypass(4'h7);
    t_bypass(4'he);
    load_instr(INSTR_IDCODE);
    t_idcode(1'b0);
    t_sample();
    t_extest();
    t_clamp();
    t_abort();
    stop_test();
  end

  // Cuts a hang short; the tests need well under 40 us.
  initial
  begin
    #100us;
    n_mismatch++;
    stop_test();
  end
endmodule : bst_tap_tb
